/* core/eeac_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants of the data EEPROM access block.
// ----------------------------------------------------------------------------
package eeac_pkg;

  // ----------------------------------------------------------------------------
  // Special register addresses on the core side.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] PERIPH_FLAG_ADDR = 8'h0C; // Holds the write-done flag.
  localparam logic [7:0] DATA_ADDR        = 8'h9A; // Data register.
  localparam logic [7:0] ADDRESS_ADDR     = 8'h9B; // Address register.
  localparam logic [7:0] CONTROL_ADDR     = 8'h9C; // Control register.
  localparam logic [7:0] UNLOCK_ADDR      = 8'h9D; // Unlock port, no storage.

  // ----------------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------------
  localparam int CTL_RD_BIT    = 0; // Read strobe.
  localparam int CTL_WR_BIT    = 1; // Write strobe.
  localparam int CTL_ALLOW_BIT = 2; // Write allow.
  localparam int CTL_ABORT_BIT = 3; // Write abort flag.
  localparam int DONE_BIT      = 7; // Write-done flag in the peripheral flag register.

  // ----------------------------------------------------------------------------
  // Unlock values, reset values and timing.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] UNLOCK_FIRST  = 8'h55; // First unlock byte.
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA; // Second unlock byte.
  localparam logic [7:0] RESET_BYTE    = 8'h00; // Data and address reset value.
  localparam int EE_DEPTH        = 128;  // Array locations.
  localparam int CLK_KHZ         = 125000; // Instruction clock rate.
  localparam int PWRUP_MS        = 72;   // Power-up timer length.
  localparam int PWRUP_CYC       = PWRUP_MS * CLK_KHZ; // Power-up hold in cycles.
  localparam int WRITE_US        = 4;    // Array write time.
  localparam int WRITE_CYC       = WRITE_US * CLK_KHZ / 1000; // Array write in cycles.
  localparam int UNLOCK_GAP_CYC  = 2;    // Exact spacing between unlock steps.

  // ----------------------------------------------------------------------------
  // Controller register map (byte addresses) and command kinds.
  // ----------------------------------------------------------------------------
  localparam logic [3:0] CMD_OFS    = 4'h0; // Command: [7:0] addr, [15:8] data, [17:16] kind.
  localparam logic [3:0] STATUS_OFS = 4'h4; // Status: [0] busy, [15:8] read byte.
  localparam logic [3:0] RESET_OFS  = 4'h8; // Reset pulses: [0] clear pin, [1] watchdog.
  localparam logic [1:0] KIND_WRITE  = 2'h0; // Plain register write.
  localparam logic [1:0] KIND_READ   = 2'h1; // Register read.
  localparam logic [1:0] KIND_UNLOCK = 2'h2; // Unlock sequence, then control write.
  localparam logic [1:0] RESP_OKAY   = 2'h0; // AXI okay.
  localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI slave error for unmapped offsets.

endpackage

/* core/eeac_sfr_if.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Special register path between the core end and the EEPROM end.
// ----------------------------------------------------------------------------
interface eeac_sfr_if;
  logic       sfr_wr;    // One-cycle register write strobe.
  logic       sfr_rd;    // One-cycle register read strobe.
  logic [7:0] sfr_addr;  // Register address.
  logic [7:0] sfr_wdata; // Write byte.
  logic [7:0] sfr_rdata; // Read byte, valid with sfr_rvalid.
  logic       sfr_rvalid;// One-cycle read answer.
  logic       external_clear_pin_rst;  // One-cycle external clear pin reset.
  logic       wdt_rst;   // One-cycle watchdog timer reset.

  modport dev  (input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, external_clear_pin_rst, wdt_rst,
                output sfr_rdata, sfr_rvalid);
  modport host (output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, external_clear_pin_rst, wdt_rst,
                input sfr_rdata, sfr_rvalid);
endinterface

/* core/eeac_dev.sv */
`timescale 1ns/1ps
// Summary of operation
// - Array address uses low seven bits only.
// - Software keeps address top bit zero.
// - Control upper four bits read zero.
// - Software can only set read/write strobes.
// - Hardware clears strobes when operation ends.
// - Array write needs write allow set.
// - Power-up forces write allow to zero.
// - Clear pin or watchdog reset during write sets abort flag.
// - Abort clears data, address; software retries.
// - Write end sets done flag; software clears.
// - Unlock port stores nothing, reads zero.
// - Load address before setting read strobe.
// - Read data appears in next cycle.
// - Data holds until read, written or cleared by abort.
// - Write needs 55h, AAh, strobe, exact timing.
// - Strobe needs allow; later clear harmless.
// - No writes while power-up timer runs.
module eeac_dev #(
  parameter int PWRUP_CYCLES = eeac_pkg::PWRUP_CYC, // Power-up write hold.
  parameter int WRITE_CYCLES = eeac_pkg::WRITE_CYC  // Array write time.
) (
  // Clock and power-on reset.
  input  wire logic  I_MCLK,
  input  wire logic  I_RST,
  // Core register path.
  eeac_sfr_if.dev    sfr,
  // Status for the user side.
  output logic       O_WRITE_BUSY,
  output logic       O_PWRUP_HOLD
);

  // ----------------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------------
  localparam int PW = $clog2(PWRUP_CYCLES + 1); // Power-up counter width.
  localparam int WW = $clog2(WRITE_CYCLES + 1); // Write counter width.

  typedef enum logic [1:0] {
    UNL_IDLE = 2'b00, // No unlock step seen.
    UNL_55   = 2'b01, // First byte seen.
    UNL_AA   = 2'b10  // Both bytes seen, strobe may follow.
  } eeac_unl_type;

  typedef struct packed {
    logic [eeac_pkg::EE_DEPTH-1:0][7:0] mem; // Byte array.
    logic [7:0]   data;       // Data register.
    logic [6:0]   addr;       // Address register, bit 7 not stored.
    logic         abort;      // Write abort flag.
    logic         allow;      // Write allow.
    logic         wr_stb;     // Write strobe, high while writing.
    logic         rd_stb;     // Read strobe, high for one cycle.
    logic         done;       // Write-done flag.
    eeac_unl_type unl;        // Unlock progress.
    logic [1:0]   gap;        // Cycles since last unlock step.
    logic [PW-1:0] pwr_cnt;   // Power-up hold count.
    logic [WW-1:0] wr_cnt;    // Remaining write cycles.
    logic [7:0]   rdata;      // Read answer.
    logic         rvalid;     // Read answer strobe.
  } eeac_dev_state_type;

  eeac_dev_state_type st_reg;  // Registered state.
  eeac_dev_state_type st_next; // Next state.

  logic soft_rst;   // Clear pin or watchdog reset this cycle.
  logic wr_ctl;     // Control register written.
  logic gap_ok;     // Unlock spacing exactly met.

  assign soft_rst = sfr.external_clear_pin_rst | sfr.wdt_rst;
  assign wr_ctl   = sfr.sfr_wr & (sfr.sfr_addr == eeac_pkg::CONTROL_ADDR);
  assign gap_ok   = (st_reg.gap == 2'(eeac_pkg::UNLOCK_GAP_CYC - 1));

  // ----------------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------------
  // All register effects are decided here; a soft reset overrides register writes, reads are still answered.
  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = 1'b0;
    st_next.rd_stb = 1'b0; // The read finishes in one cycle.

    // Power-up timer runs down after power-on only.
    if (st_reg.pwr_cnt != '0) begin
      st_next.pwr_cnt = st_reg.pwr_cnt - PW'(1);
    end

    // Unlock spacing counter saturates so a slow sequence falls out.
    if (st_reg.gap != 2'h3) begin
      st_next.gap = st_reg.gap + 2'h1;
    end
    if (st_reg.unl != UNL_IDLE && st_reg.gap > 2'(eeac_pkg::UNLOCK_GAP_CYC - 1)) begin
      st_next.unl = UNL_IDLE;
    end

    // Array write in progress; the allow bit no longer matters here.
    if (st_reg.wr_stb) begin
      if (st_reg.wr_cnt == '0) begin
        st_next.mem[st_reg.addr] = st_reg.data;
        st_next.wr_stb           = 1'b0;
        st_next.done             = 1'b1;
      end else begin
        st_next.wr_cnt = st_reg.wr_cnt - WW'(1);
      end
    end

    if (soft_rst) begin
      // A reset that lands on a running write leaves a trace and wipes the operands.
      if (st_reg.wr_stb) begin
        st_next.abort = 1'b1;
        st_next.data  = eeac_pkg::RESET_BYTE;
        st_next.addr  = 7'(eeac_pkg::RESET_BYTE);
      end
      st_next.allow  = 1'b0;
      st_next.wr_stb = 1'b0;
      st_next.done   = 1'b0;
      st_next.unl    = UNL_IDLE;
    end else if (sfr.sfr_wr) begin
      // Any register write other than the expected next step breaks the sequence.
      if (sfr.sfr_addr != eeac_pkg::UNLOCK_ADDR) begin
        st_next.unl = UNL_IDLE;
      end
      case (sfr.sfr_addr)
        eeac_pkg::DATA_ADDR: begin
          // Operands are frozen while the array is being written.
          if (!st_reg.wr_stb) begin
            st_next.data = sfr.sfr_wdata;
          end
        end
        eeac_pkg::ADDRESS_ADDR: begin
          if (!st_reg.wr_stb) begin
            st_next.addr = sfr.sfr_wdata[6:0];
          end
        end
        eeac_pkg::CONTROL_ADDR: begin
          // Abort and allow take the written bits, so software can set abort as well as clear it.
          st_next.abort = sfr.sfr_wdata[eeac_pkg::CTL_ABORT_BIT];
          st_next.allow = sfr.sfr_wdata[eeac_pkg::CTL_ALLOW_BIT];
          // Zeros on the strobes do nothing; ones are taken only when idle.
          if (!st_reg.wr_stb) begin
            if (sfr.sfr_wdata[eeac_pkg::CTL_RD_BIT]) begin
              st_next.rd_stb = 1'b1;
              st_next.data   = st_reg.mem[st_reg.addr];
            end else if (sfr.sfr_wdata[eeac_pkg::CTL_WR_BIT] && st_reg.allow &&
                         st_reg.unl == UNL_AA && gap_ok &&
                         st_reg.pwr_cnt == '0) begin
              st_next.wr_stb = 1'b1;
              st_next.wr_cnt = WW'(WRITE_CYCLES - 1);
            end
          end
        end
        eeac_pkg::UNLOCK_ADDR: begin
          // Nothing is stored; the byte only advances the sequence.
          st_next.gap = 2'h0;
          if (sfr.sfr_wdata == eeac_pkg::UNLOCK_FIRST) begin
            st_next.unl = UNL_55;
          end else if (sfr.sfr_wdata == eeac_pkg::UNLOCK_SECOND && st_reg.unl == UNL_55 && gap_ok) begin
            st_next.unl = UNL_AA;
          end else begin
            st_next.unl = UNL_IDLE;
          end
        end
        eeac_pkg::PERIPH_FLAG_ADDR: begin
          // Software clears the done flag here, and a finishing write still wins.
          if (!sfr.sfr_wdata[eeac_pkg::DONE_BIT] && !(st_reg.wr_stb && st_reg.wr_cnt == '0)) begin
            st_next.done = 1'b0;
          end
        end
        default: begin
          st_next.unl = UNL_IDLE;
        end
      endcase
    end

    // Read answers come one cycle after the strobe.
    if (sfr.sfr_rd) begin
      st_next.rvalid = 1'b1;
      case (sfr.sfr_addr)
        eeac_pkg::DATA_ADDR:        st_next.rdata = st_reg.data;
        eeac_pkg::ADDRESS_ADDR:     st_next.rdata = {1'b0, st_reg.addr};
        eeac_pkg::CONTROL_ADDR:     st_next.rdata = {4'h0, st_reg.abort, st_reg.allow,
                                                     st_reg.wr_stb, st_reg.rd_stb};
        eeac_pkg::PERIPH_FLAG_ADDR: st_next.rdata = {st_reg.done, 7'h00};
        default:                    st_next.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------------
  // Power-on clears write allow and loads the power-up hold.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      st_reg         <= '0;
      st_reg.pwr_cnt <= PW'(PWRUP_CYCLES);
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------------
  assign sfr.sfr_rdata  = st_reg.rdata;
  assign sfr.sfr_rvalid = st_reg.rvalid;
  assign O_WRITE_BUSY   = st_reg.wr_stb;
  assign O_PWRUP_HOLD   = (st_reg.pwr_cnt != '0);

endmodule // eeac_dev

/* core/eeac_host.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Core end: takes commands over AXI4-Lite and drives the special register path.
// ----------------------------------------------------------------------------
module eeac_host (
  // Clock and reset.
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  // AXI4-Lite write address and data.
  input  wire logic [3:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  // AXI4-Lite write response.
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // AXI4-Lite read.
  input  wire logic [3:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // Register path to the EEPROM end.
  eeac_sfr_if.host         sfr
);

  // ----------------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        awready; // Address slot free.
    logic        wready;  // Data slot free.
    logic [3:0]  awaddr;  // Held write address.
    logic [31:0] wdata;   // Held write data.
    logic [3:0]  wstrb;   // Held byte enables.
    logic        bvalid;  // Write response pending.
    logic [1:0]  bresp;   // Write response code.
    logic        arready; // Read address slot free.
    logic        rvalid;  // Read data pending.
    logic [1:0]  rresp;   // Read response code.
    logic [31:0] rdata;   // Read data.
    logic [17:0] cmd;     // Current command.
    logic        busy;    // Sequence running.
    logic [1:0]  step;    // Step of the unlock sequence.
    logic [1:0]  gap;     // Wait count between steps.
    logic        wait_rd; // Read answer outstanding.
    logic [7:0]  result;  // Last read byte.
    logic        wr;      // Register write strobe.
    logic        rd;      // Register read strobe.
    logic [7:0]  addr;    // Register address.
    logic [7:0]  wbyte;   // Register write byte.
    logic        external_clear_pin;    // Clear pin reset pulse.
    logic        wdt;     // Watchdog reset pulse.
  } eeac_host_state_type;

  eeac_host_state_type st_reg;  // Registered state.
  eeac_host_state_type st_next; // Next state.

  logic aw_have; // Address held or arriving.
  logic w_have;  // Data held or arriving.

  assign aw_have = !st_reg.awready || I_AWVALID;
  assign w_have  = !st_reg.wready || I_WVALID;

  // ----------------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------------
  // Address and data are caught in any order; the write happens once both are in.
  always_comb begin
    st_next      = st_reg;
    st_next.wr   = 1'b0;
    st_next.rd   = 1'b0;
    st_next.external_clear_pin = 1'b0;
    st_next.wdt  = 1'b0;

    if (st_reg.awready && I_AWVALID) begin
      st_next.awready = 1'b0;
      st_next.awaddr  = I_AWADDR;
    end
    if (st_reg.wready && I_WVALID) begin
      st_next.wready = 1'b0;
      st_next.wdata  = I_WDATA;
      st_next.wstrb  = I_WSTRB;
    end
    if (st_reg.bvalid && I_BREADY) begin
      st_next.bvalid  = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end
    if (!st_reg.awready && !st_reg.wready && !st_reg.bvalid) begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = eeac_pkg::RESP_OKAY;
      case (st_reg.awaddr)
        eeac_pkg::CMD_OFS: begin
          // A command that arrives while one runs is dropped.
          if (!st_reg.busy && st_reg.wstrb[0]) begin
            st_next.cmd  = st_reg.wdata[17:0];
            st_next.busy = 1'b1;
            st_next.step = 2'h0;
            st_next.gap  = 2'h0;
          end
        end
        eeac_pkg::RESET_OFS: begin
          st_next.external_clear_pin = st_reg.wdata[0] & st_reg.wstrb[0];
          st_next.wdt  = st_reg.wdata[1] & st_reg.wstrb[0];
        end
        eeac_pkg::STATUS_OFS: begin
        end
        default: st_next.bresp = eeac_pkg::RESP_SLVERR;
      endcase
    end

    // Reads answer one cycle after the address is taken.
    if (st_reg.rvalid && I_RREADY) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end
    if (st_reg.arready && I_ARVALID) begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rresp   = eeac_pkg::RESP_OKAY;
      case (I_ARADDR)
        eeac_pkg::CMD_OFS:    st_next.rdata = {14'h0000, st_reg.cmd};
        eeac_pkg::STATUS_OFS: st_next.rdata = {16'h0000, st_reg.result, 7'h00, st_reg.busy};
        eeac_pkg::RESET_OFS:  st_next.rdata = 32'h0000_0000;
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = eeac_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Register path sequencer; unlock steps keep exact spacing.
    if (st_reg.wait_rd) begin
      if (sfr.sfr_rvalid) begin
        st_next.result  = sfr.sfr_rdata;
        st_next.wait_rd = 1'b0;
        st_next.busy    = 1'b0;
      end
    end else if (st_reg.busy) begin
      st_next.addr  = st_reg.cmd[7:0];
      st_next.wbyte = st_reg.cmd[15:8];
      case (st_reg.cmd[17:16])
        eeac_pkg::KIND_READ: begin
          st_next.rd      = 1'b1;
          st_next.wait_rd = 1'b1;
        end
        eeac_pkg::KIND_UNLOCK: begin
          if (st_reg.gap != 2'h0) begin
            st_next.gap = st_reg.gap - 2'h1;
          end else begin
            st_next.wr  = 1'b1;
            st_next.gap = 2'(eeac_pkg::UNLOCK_GAP_CYC - 1);
            st_next.step = st_reg.step + 2'h1;
            case (st_reg.step)
              2'h0: begin
                st_next.addr  = eeac_pkg::UNLOCK_ADDR;
                st_next.wbyte = eeac_pkg::UNLOCK_FIRST;
              end
              2'h1: begin
                st_next.addr  = eeac_pkg::UNLOCK_ADDR;
                st_next.wbyte = eeac_pkg::UNLOCK_SECOND;
              end
              default: begin
                st_next.busy = 1'b0;
              end
            endcase
          end
        end
        default: begin
          st_next.wr   = 1'b1;
          st_next.busy = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      st_reg         <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready  <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------------
  assign O_AWREADY     = st_reg.awready;
  assign O_WREADY      = st_reg.wready;
  assign O_BVALID      = st_reg.bvalid;
  assign O_BRESP       = st_reg.bresp;
  assign O_ARREADY     = st_reg.arready;
  assign O_RVALID      = st_reg.rvalid;
  assign O_RRESP       = st_reg.rresp;
  assign O_RDATA       = st_reg.rdata;
  assign sfr.sfr_wr    = st_reg.wr;
  assign sfr.sfr_rd    = st_reg.rd;
  assign sfr.sfr_addr  = st_reg.addr;
  assign sfr.sfr_wdata = st_reg.wbyte;
  assign sfr.external_clear_pin_rst  = st_reg.external_clear_pin;
  assign sfr.wdt_rst   = st_reg.wdt;

endmodule // eeac_host

/* sim/eeac_sva.sv */
`timescale 1ns/1ps
// ----
// Checks on the register path between the two ends.
// ----
module eeac_sva #(
  parameter int WRITE_CYCLES = eeac_pkg::WRITE_CYC // Array write time.
) (
  // Clock and reset.
  input wire logic       I_MCLK,
  input wire logic       I_RST,
  // Register path.
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_rvalid,
  input wire logic       external_clear_pin_rst,
  input wire logic       wdt_rst,
  // Write progress.
  input wire logic       O_WRITE_BUSY
);
  logic [15:0] run_reg, run_next; // Busy cycles of this write.
  logic        go_reg, go_next;   // Write strobe set one cycle ago.
  // A counter, because the write time is too long to unroll.
  always_comb begin
    run_next = O_WRITE_BUSY ? run_reg + 16'h0001 : 16'h0000;
    go_next  = sfr_wr && sfr_addr == eeac_pkg::CONTROL_ADDR && sfr_wdata[eeac_pkg::CTL_WR_BIT];
  end
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      run_reg <= 16'h0000;
      go_reg  <= 1'b0;
    end else begin
      run_reg <= run_next;
      go_reg  <= go_next;
    end
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  sequence s_rd(logic [7:0] a); sfr_rd && sfr_addr == a; endsequence
  property p_rd_ans; sfr_rd |=> sfr_rvalid; endproperty
  property p_rv_cause; sfr_rvalid |-> $past(sfr_rd); endproperty
  property p_unl_zero; s_rd(eeac_pkg::UNLOCK_ADDR) |=> sfr_rdata == 8'h00; endproperty
  property p_ctl_top; s_rd(eeac_pkg::CONTROL_ADDR) |=> sfr_rdata[7:4] == 4'h0; endproperty
  property p_hold; !sfr_rvalid |-> $stable(sfr_rdata); endproperty
  property p_start; $rose(O_WRITE_BUSY) |-> go_reg; endproperty
  property p_abort; O_WRITE_BUSY && (external_clear_pin_rst || wdt_rst) |=> !O_WRITE_BUSY; endproperty
  property p_len; $fell(O_WRITE_BUSY) && !$past(external_clear_pin_rst) && !$past(wdt_rst) |-> run_reg == 16'(WRITE_CYCLES);
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered next cycle");
  a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
  a_unl_zero: assert property (p_unl_zero) else $error("unlock port read not zero");
  a_ctl_top: assert property (p_ctl_top) else $error("control upper bits not zero");
  a_hold: assert property (p_hold) else $error("read byte changed without read");
  a_start: assert property (p_start) else $error("write began without strobe");
  a_abort: assert property (p_abort) else $error("write not dropped on reset");
  a_len: assert property (p_len) else $error("write length wrong");
endmodule // eeac_sva

/* sim/data_eeprom_access_control_bench.sv */
`timescale 1ns/1ps
// ----
// Bench driving AXI into the core end; the two ends face each other.
// ----
module data_eeprom_access_control_bench;
  localparam int WR_CYC = 40; // Long enough to land a reset mid-write.
  typedef struct packed {logic al; logic [7:0] wl, dt, rl, ex;} eeac_row_type;
  // Allow, write location, byte, read location, expected byte.
  eeac_row_type rows [4] = '{'{1'b1, 8'h00, 8'h11, 8'h00, 8'h11}, '{1'b1, 8'h7F, 8'hA5, 8'h7F, 8'hA5},
                             '{1'b1, 8'h85, 8'h3C, 8'h05, 8'h3C}, '{1'b0, 8'h00, 8'h77, 8'h00, 8'h11}};
  logic mclk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, s;
  logic [7:0] v;
  logic [1:0] r;
  wire aw_rdy, w_rdy, bv, ar_rdy, rv, busy, hold;
  wire [1:0] bresp, rresp;
  wire [31:0] rdat;
  int mismatches = 0, num_checks = 0;
  always #4 mclk = ~mclk;
  eeac_sfr_if i_eeac_sfr_if ();
  eeac_host i_eeac_host (.I_MCLK(mclk), .I_RST(rst), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(aw_rdy),
    .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(w_rdy), .O_BRESP(bresp), .O_BVALID(bv),
    .I_BREADY(br), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(ar_rdy), .O_RDATA(rdat), .O_RRESP(rresp),
    .O_RVALID(rv), .I_RREADY(rr), .sfr(i_eeac_sfr_if));
  eeac_dev #(.PWRUP_CYCLES(200), .WRITE_CYCLES(WR_CYC)) i_eeac_dev (.I_MCLK(mclk), .I_RST(rst),
    .sfr(i_eeac_sfr_if), .O_WRITE_BUSY(busy), .O_PWRUP_HOLD(hold));
  eeac_sva #(.WRITE_CYCLES(WR_CYC)) i_eeac_sva (.I_MCLK(mclk), .I_RST(rst), .sfr_wr(i_eeac_sfr_if.sfr_wr),
    .sfr_rd(i_eeac_sfr_if.sfr_rd), .sfr_addr(i_eeac_sfr_if.sfr_addr), .sfr_wdata(i_eeac_sfr_if.sfr_wdata),
    .sfr_rdata(i_eeac_sfr_if.sfr_rdata), .sfr_rvalid(i_eeac_sfr_if.sfr_rvalid),
    .external_clear_pin_rst(i_eeac_sfr_if.external_clear_pin_rst), .wdt_rst(i_eeac_sfr_if.wdt_rst), .O_WRITE_BUSY(busy));
  task automatic chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Each channel is released at its own handshake edge.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge mclk);
      if (aw_rdy) awv <= 1'b0;
      if (w_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    r = bresp;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge mclk);
      if (ar_rdy) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    s = rdat;
    r = rresp;
  endtask
  // A command is finished once the status shows the core end idle.
  task automatic op(input logic [1:0] k, logic [7:0] a, b);
    axi_wr(eeac_pkg::CMD_OFS, {14'h0, k, b, a});
    s = 32'h1;
    while (s[0] !== 1'b0) axi_rd(eeac_pkg::STATUS_OFS);
  endtask
  task automatic wr(input logic [7:0] a, b);
    op(eeac_pkg::KIND_WRITE, a, b);
  endtask
  task automatic rd(input logic [7:0] a);
    op(eeac_pkg::KIND_READ, a, 8'h00);
    axi_rd(eeac_pkg::STATUS_OFS);
    v = s[15:8];
  endtask
  task automatic ld(input logic al, logic [7:0] lc, dt);
    wr(eeac_pkg::CONTROL_ADDR, {5'h0, al, 2'h0});
    wr(eeac_pkg::DATA_ADDR, dt);
    wr(eeac_pkg::ADDRESS_ADDR, lc);
    op(eeac_pkg::KIND_UNLOCK, eeac_pkg::CONTROL_ADDR, {5'h0, al, 2'h2});
  endtask
  task automatic fetch(input logic [7:0] lc);
    wr(eeac_pkg::ADDRESS_ADDR, lc);
    wr(eeac_pkg::CONTROL_ADDR, 8'h01);
    rd(eeac_pkg::DATA_ADDR);
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    results();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(eeac_pkg::CONTROL_ADDR);
    chk("control", 8'h00, v);
    ld(1'b1, 8'h40, 8'h5A);
    chk("busy", 8'h00, {7'h0, busy});
    chk("hold", 8'h01, {7'h0, hold});
    $display("Power-up test done");
    while (hold !== 1'b0) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      ld(rows[i].al, rows[i].wl, rows[i].dt);
      while (busy !== 1'b0) @(posedge mclk);
      rd(eeac_pkg::PERIPH_FLAG_ADDR);
      chk("done", {rows[i].al, 7'h0}, v & 8'h80);
      wr(eeac_pkg::PERIPH_FLAG_ADDR, 8'h00);
      fetch(rows[i].rl);
      chk("data", rows[i].ex, v);
      rd(eeac_pkg::CONTROL_ADDR);
      chk("control", 8'h00, v);
      $display("Row %0d done", i);
    end
    ld(1'b1, 8'h30, 8'h5A);
    wr(eeac_pkg::CONTROL_ADDR, 8'h04);
    wr(eeac_pkg::DATA_ADDR, 8'h99);
    while (busy !== 1'b0) @(posedge mclk);
    fetch(8'h30);
    chk("kept", 8'h5A, v);
    for (int k = 1; k < 3; k++) begin
      ld(1'b1, 8'h22, 8'hC3);
      axi_wr(eeac_pkg::RESET_OFS, 32'(k));
      rd(eeac_pkg::CONTROL_ADDR);
      chk("abort", 8'h08, v);
      rd(eeac_pkg::DATA_ADDR);
      chk("data", 8'h00, v);
      rd(eeac_pkg::ADDRESS_ADDR);
      chk("address", 8'h00, v);
      wr(eeac_pkg::CONTROL_ADDR, 8'h00);
      rd(eeac_pkg::CONTROL_ADDR);
      chk("cleared", 8'h00, v);
      $display("Abort test %0d done", k);
    end
    axi_wr(4'hC, 32'h0);
    chk("bresp", {6'h0, eeac_pkg::RESP_SLVERR}, {6'h0, r});
    axi_rd(4'hC);
    chk("rresp", {6'h0, eeac_pkg::RESP_SLVERR}, {6'h0, r});
    chk("rdata", 8'h00, s[7:0]);
    rd(eeac_pkg::UNLOCK_ADDR);
    chk("unlock", 8'h00, v);
    $display("Odd cases done");
    results();
  end
endmodule // data_eeprom_access_control_bench
